// [hdl/vlcp_defs.svh]
// constants for the voltage loop compensator and pulse engine
`ifndef VLCP_DEFS_SVH
`define VLCP_DEFS_SVH
`define VLCP_ERR_MIN      6'sh20
`define VLCP_ERR_MAX      6'sh1f
`define VLCP_DAC_W        10
`define VLCP_PER_W        12
`define VLCP_DUTY_W       12
`define VLCP_DUTY_FULL    12'hfff
`define VLCP_CLK_MHZ      20
// slew 0.156 V/ms; in 1 mV dac steps that is 156 steps per ms
`define VLCP_SLEW_STEPS_PER_MS 156
`define VLCP_SLEW_DIV     ((`VLCP_CLK_MHZ * 1000) / `VLCP_SLEW_STEPS_PER_MS)
`define VLCP_SYNC_OFF_MAX 8'h03
`define VLCP_BANK_RAMP    2'h0
`define VLCP_BANK_NORM    2'h1
`define VLCP_BANK_LIGHT   2'h2
`define VLCP_ACC_W        24
`endif

// [hdl/vlcp_pkg.sv]
// types shared by the compensator and pulse engine
package vlcp_pkg;
  // one coefficient bank, gain code included
  typedef struct packed {
    logic [1:0]        front_gain_code;
    logic signed [5:0] lim0;
    logic signed [5:0] lim1;
    logic signed [5:0] lim2;
    logic signed [5:0] lim3;
    logic signed [7:0] nlg0;
    logic signed [7:0] nlg1;
    logic signed [7:0] nlg2;
    logic signed [7:0] nlg3;
    logic signed [7:0] nlg4;
    logic signed [11:0] b0;
    logic signed [11:0] b1;
    logic signed [11:0] b2;
    logic signed [11:0] a1;
    logic signed [11:0] a2;
    logic signed [11:0] c0;
    logic signed [11:0] c1;
    logic signed [11:0] d1;
  } vlcp_bank_t;
  typedef struct packed {
    logic [7:0] sync_out_sel;
    logic [7:0] sync_in_mask;
  } vlcp_sync_t;
  typedef enum logic [1:0] {VLCP_ST_IDLE, VLCP_ST_NLG, VLCP_ST_IIR2, VLCP_ST_IIR1} vlcp_state_t;
endpackage

// [hdl/vlcp_pulse_engine.sv]
// period counter and comparator pulse engine for one rail
`timescale 1ns/1ps
`include "vlcp_defs.svh"
module vlcp_pulse_engine
  import vlcp_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic [`VLCP_PER_W-1:0]   period,     // switching period in clocks
  input  wire logic [`VLCP_DUTY_W-1:0]  duty,       // fraction of full scale
  input  wire logic                     duty_stb,   // new duty available
  input  wire logic                     sync_clr,   // restart counter
  output logic                          gate_out,   // gate drive
  output logic                          period_end  // boundary pulse
);
  logic [`VLCP_PER_W-1:0] cnt_reg;    // free-running period counter
  logic [`VLCP_PER_W-1:0] thr_reg;    // active compare threshold
  logic [`VLCP_PER_W-1:0] pend_reg;   // pending threshold
  logic                   gate_reg;
  logic [2*`VLCP_PER_W-1:0] prod;     // duty times period
  wire  [`VLCP_PER_W-1:0] thr_next = prod[2*`VLCP_PER_W-1:`VLCP_PER_W];
  wire                    wrap     = (cnt_reg >= period - 12'h001);
  assign prod = duty * period;
  assign period_end = wrap | sync_clr;
  assign gate_out = gate_reg;
  // counter wraps on period or restarts on sync
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= 12'h000;
      thr_reg  <= 12'h000;
      pend_reg <= 12'h000;
      gate_reg <= 1'b0;
    end
    else
    begin
      if (period_end)
        cnt_reg <= 12'h000;
      else
        cnt_reg <= cnt_reg + 12'h001;
      if (duty_stb)
        pend_reg <= thr_next;
      // threshold only changes at a boundary so no glitch pulse
      if (period_end)
        thr_reg <= duty_stb ? thr_next : pend_reg;
      gate_reg <= (cnt_reg < thr_reg);
    end
  end
  AST_GATE_LOW_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (thr_reg == 12'h000) |=> !gate_reg) else $error("gate high at zero duty");
  AST_CNT_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_clr |=> (cnt_reg == 12'h000)) else $error("sync did not clear counter");
  AST_THR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !period_end |=> $stable(thr_reg)) else $error("threshold moved mid period");
endmodule

// [hdl/vlcp_loop.sv]
// one-rail voltage loop: sample, error, nonlinear gain, iir cascade, pwm
// Notes on behaviour
// - sample sense once per period at programmed time
// - error is ten-bit setpoint minus sensed voltage
// - two-bit code picks gain 1, 2, 4, 8
// - code sets 8,4,2,1 mV step and range
// - converter clamps error to -32 or +31
// - saturated: slew setpoint toward sense, 0.156 V/ms
// - gain code lives inside each coefficient bank
// - bank 0 ramps, 1 normal, 2 light load
// - nonlinear gain, then second-order, then first-order
// - first-order section adds third pole and zero
// - four limits choose among five gains, any sign
// - duty fraction times period gives threshold
// - counter compared with threshold drives gate
// - sync in/out selected by configuration word
// - rising sync input restarts followed rail counter
// - upper byte picks sync out, lower byte follow
`timescale 1ns/1ps
`include "vlcp_defs.svh"
module vlcp_loop
  import vlcp_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic [`VLCP_DAC_W-1:0]  sense_mv,            // differential sense, 1 mV units
  input  wire logic [`VLCP_DAC_W-1:0]  vref_target,         // commanded setpoint
  input  wire logic [`VLCP_PER_W-1:0]  error_sample_time_cmd,
  input  wire logic [`VLCP_PER_W-1:0]  period,
  input  wire vlcp_bank_t              bank0,
  input  wire vlcp_bank_t              bank1,
  input  wire vlcp_bank_t              bank2,
  input  wire logic                    ramp_active,         // soft start/stop/track
  input  wire logic                    light_load,          // current below threshold
  input  wire vlcp_sync_t              sync_cfg,
  input  wire logic                    sync_in,
  input  wire logic                    peer_period_end,     // other engine boundary
  input  wire logic [1:0]              rail_index,          // this engine's number
  output logic                         gate_out,
  output logic                         sync_out,
  output logic signed [5:0]            error_code,          // clamped converter code
  output logic                         err_saturated,
  output logic [`VLCP_DAC_W-1:0]       dac_value,
  output logic [`VLCP_DUTY_W-1:0]      duty_value,
  output logic [1:0]                   active_bank
);
  // ---- state ----
  logic [`VLCP_PER_W-1:0]  tcnt_reg;         // sample timer within period
  logic [`VLCP_DAC_W-1:0]  dac_reg;          // setpoint dac
  logic signed [5:0]       err_reg;
  logic                    sat_reg;
  logic                    smp_reg;          // sample strobe, starts filter
  logic                    sync_d_reg;       // previous sync level for edge
  logic [15:0]             slew_cnt_reg;     // slew rate divider
  vlcp_state_t             st_reg;
  vlcp_bank_t              cur_reg;          // bank latched per calculation
  logic [1:0]              bank_reg;
  logic signed [`VLCP_ACC_W-1:0] x1_reg, x2_reg, y1_reg, y2_reg; // biquad history
  logic signed [`VLCP_ACC_W-1:0] u1_reg, z1_reg;                  // first-order history
  logic signed [`VLCP_ACC_W-1:0] nl_reg, s2_reg, s1_reg;
  logic [`VLCP_DUTY_W-1:0] duty_reg;
  logic                    duty_stb_reg;
  logic                    pe_end;
  // bank select
  wire [1:0] bank_sel = ramp_active ? `VLCP_BANK_RAMP :
                        light_load  ? `VLCP_BANK_LIGHT : `VLCP_BANK_NORM;
  wire vlcp_bank_t bank_pick = (bank_sel == `VLCP_BANK_RAMP)  ? bank0 :
                               (bank_sel == `VLCP_BANK_LIGHT) ? bank2 : bank1;
  // error path: setpoint minus sense, scaled by gain
  wire signed [`VLCP_DAC_W+1:0] diff_mv = $signed({2'b00, dac_reg}) - $signed({2'b00, sense_mv});
  // gain code g gives 2^(3-g) mV per step, so shift right by 3-g
  wire [1:0] gcode = cur_reg.front_gain_code;
  wire signed [`VLCP_DAC_W+1:0] err_steps = diff_mv >>> (2'd3 - gcode);
  wire       hi_sat = err_steps > $signed(12'sd31);
  wire       lo_sat = err_steps < -$signed(12'sd32);
  wire signed [5:0] err_clamped = hi_sat ? `VLCP_ERR_MAX :
                                  lo_sat ? `VLCP_ERR_MIN : err_steps[5:0];
  // sample point
  wire smp_now = (tcnt_reg == error_sample_time_cmd);
  // sync
  wire sync_rise = sync_in & ~sync_d_reg;
  wire follow    = sync_cfg.sync_in_mask[rail_index];
  wire sync_clr  = follow & sync_rise;
  wire drive_out = (sync_cfg.sync_out_sel <= `VLCP_SYNC_OFF_MAX) &&
                   (sync_cfg.sync_out_sel[1:0] == rail_index);
  assign sync_out = drive_out ? gate_out : 1'b0;
  // nonlinear gain region
  wire signed [7:0] nl_gain = (err_reg < cur_reg.lim0) ? cur_reg.nlg0 :
                              (err_reg < cur_reg.lim1) ? cur_reg.nlg1 :
                              (err_reg < cur_reg.lim2) ? cur_reg.nlg2 :
                              (err_reg < cur_reg.lim3) ? cur_reg.nlg3 : cur_reg.nlg4;
  // ---- filter arithmetic ----
  wire signed [`VLCP_ACC_W-1:0] nl_val = `VLCP_ACC_W'(err_reg * nl_gain);
  wire signed [`VLCP_ACC_W+11:0] bq = nl_reg * cur_reg.b0 + x1_reg * cur_reg.b1
                                   + x2_reg * cur_reg.b2 - y1_reg * cur_reg.a1
                                   - y2_reg * cur_reg.a2;
  wire signed [`VLCP_ACC_W-1:0] bq_s = `VLCP_ACC_W'(bq >>> 8);
  wire signed [`VLCP_ACC_W+11:0] fo = s2_reg * cur_reg.c0 + u1_reg * cur_reg.c1
                                   - z1_reg * cur_reg.d1;
  wire signed [`VLCP_ACC_W-1:0] fo_s = `VLCP_ACC_W'(fo >>> 8);
  // clamp to 0..full scale
  wire [`VLCP_DUTY_W-1:0] duty_next = (fo_s < 0) ? 12'h000 :
                     (fo_s > $signed({12'h000, `VLCP_DUTY_FULL})) ? `VLCP_DUTY_FULL :
                     fo_s[`VLCP_DUTY_W-1:0];
  // ---- front end: timer, capture, saturation slew ----
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tcnt_reg     <= 12'h000;
      dac_reg      <= 10'h000;
      err_reg      <= 6'sh00;
      sat_reg      <= 1'b0;
      smp_reg      <= 1'b0;
      sync_d_reg   <= 1'b0;
      slew_cnt_reg <= 16'h0000;
    end
    else
    begin
      sync_d_reg <= sync_in;
      tcnt_reg   <= pe_end ? 12'h000 : tcnt_reg + 12'h001;
      smp_reg    <= smp_now;
      if (smp_now)
      begin
        err_reg <= err_clamped;
        sat_reg <= hi_sat | lo_sat;
      end
      // slew toward sense while saturated, else settle on target
      if (sat_reg)
      begin
        if (slew_cnt_reg >= 16'(`VLCP_SLEW_DIV - 1))
        begin
          slew_cnt_reg <= 16'h0000;
          if (dac_reg > sense_mv)
            dac_reg <= dac_reg - 10'h001;
          else if (dac_reg < sense_mv)
            dac_reg <= dac_reg + 10'h001;
        end
        else
          slew_cnt_reg <= slew_cnt_reg + 16'h0001;
      end
      else
      begin
        slew_cnt_reg <= 16'h0000;
        dac_reg      <= vref_target;
      end
    end
  end
  // filter sequencer: nonlinear gain, biquad, first order
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_reg <= VLCP_ST_IDLE;
      cur_reg <= '0;
      bank_reg <= `VLCP_BANK_NORM;
      {x1_reg, x2_reg, y1_reg, y2_reg, u1_reg, z1_reg} <= '0;
      {nl_reg, s2_reg, s1_reg} <= '0;
      duty_reg <= 12'h000;
      duty_stb_reg <= 1'b0;
    end
    else
    begin
      duty_stb_reg <= 1'b0;
      case (st_reg)
        VLCP_ST_IDLE:
        begin
          // bank only swapped while idle, never mid calculation
          cur_reg  <= bank_pick;
          bank_reg <= bank_sel;
          if (smp_reg)
            st_reg <= VLCP_ST_NLG;
        end
        VLCP_ST_NLG:
        begin
          nl_reg <= nl_val;
          st_reg <= VLCP_ST_IIR2;
        end
        VLCP_ST_IIR2:
        begin
          s2_reg <= bq_s;
          x2_reg <= x1_reg;
          x1_reg <= nl_reg;
          y2_reg <= y1_reg;
          y1_reg <= bq_s;
          st_reg <= VLCP_ST_IIR1;
        end
        VLCP_ST_IIR1:
        begin
          s1_reg <= fo_s;
          u1_reg <= s2_reg;
          z1_reg <= fo_s;
          duty_reg <= duty_next;
          duty_stb_reg <= 1'b1;
          st_reg <= VLCP_ST_IDLE;
        end
        default:
          st_reg <= VLCP_ST_IDLE;
      endcase
    end
  end
  // follow the peer engine when this rail's follow bit is set, sync out selects it and it is not this rail
  wire peer_follow = (sync_cfg.sync_out_sel <= `VLCP_SYNC_OFF_MAX) && !drive_out && follow;
  vlcp_pulse_engine u_pe
  (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .period     (period),
    .duty       (duty_reg),
    .duty_stb   (duty_stb_reg),
    .sync_clr   (sync_clr | (peer_follow & peer_period_end)),
    .gate_out   (gate_out),
    .period_end (pe_end)
  );
  assign error_code    = err_reg;
  assign err_saturated = sat_reg;
  assign dac_value     = dac_reg;
  assign duty_value    = duty_reg;
  assign active_bank   = bank_reg;
  // ---- checks ----
  // sample strobe, then nonlinear, biquad and first-order steps, then the duty strobe
  sequence s_calc;
    smp_reg ##4 duty_stb_reg;
  endsequence
  AST_ONE_DUTY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (smp_reg && st_reg == VLCP_ST_IDLE) |-> s_calc) else $error("no duty after sample");
  AST_CLAMP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    smp_now && hi_sat |=> err_reg == `VLCP_ERR_MAX) else $error("high clamp wrong");
  AST_CLAMP_LO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    smp_now && lo_sat |=> err_reg == `VLCP_ERR_MIN) else $error("low clamp wrong");
  AST_BANK_STABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_reg != VLCP_ST_IDLE |=> $stable(cur_reg)) else $error("bank changed mid calc");
  AST_BANK_RAMP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ramp_active && st_reg == VLCP_ST_IDLE |=> bank_reg == `VLCP_BANK_RAMP)
    else $error("ramp bank not used");
  // while saturated the dac moves at most one step per clock, and only toward sense
  AST_SLEW_DIR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sat_reg |=> (($past(dac_reg) > $past(sense_mv)) ? ($past(dac_reg) - dac_reg <= 10'h001)
    : (dac_reg - $past(dac_reg) <= 10'h001))) else $error("dac slew wrong");
  AST_SYNC_OUT_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_cfg.sync_out_sel > `VLCP_SYNC_OFF_MAX |-> !sync_out) else $error("sync out enabled");
  // the error code may only move at the programmed sample point
  AST_SAMPLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !smp_now |=> $stable(err_reg)) else $error("error changed off the sample point");
  // a negative filter result must leave a zero duty
  AST_DUTY_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    duty_stb_reg && ($past(fo_s) < 0) |-> duty_reg == 12'h000) else $error("duty not clamped");
endmodule

// [verification/vlcp_stage_model.sv]
// stand-in for the power stage and output sense: turns a wanted level into sensed mv
`timescale 1ns/1ps
module vlcp_stage_model
  import vlcp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [9:0] level_mv, // level the output settles to
  input  wire logic       slow,     // walk 1 mv per clock instead of jumping
  output logic [9:0]      sense_mv
);
  logic [9:0] sense_reg = 10'h000; // settled output as seen at the sense pins
  // slow mode mimics a heavy output cap; prompt mode lands in one clock
  always_ff @(posedge ref_clk)
  begin
    if (!slow)
      sense_reg <= level_mv;
    else if (sense_reg < level_mv)
      sense_reg <= sense_reg + 10'h001;
    else if (sense_reg > level_mv)
      sense_reg <= sense_reg - 10'h001;
  end
  assign sense_mv = sense_reg;
endmodule

// [verification/vlcp_loop_bench.sv]
// self-checking bench for the one-rail voltage loop and pulse engine
`timescale 1ns/1ps
`include "vlcp_defs.svh"
module vlcp_loop_bench;
  import vlcp_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [9:0]        vref_target = 10'h000; // setpoint command
  logic [9:0]        level_mv = 10'h000;    // level the stage model settles to
  logic              slow = 1'b1;           // model walks while the rail ramps up
  logic [11:0]       period = 12'h020;      // short period keeps the run brief
  vlcp_bank_t        bank0, bank1, bank2;
  logic              ramp_active = 1'b0;
  logic              light_load = 1'b0;
  vlcp_sync_t        sync_cfg = 16'hff00;   // sync output off, no following
  logic              sync_in = 1'b0;
  logic              peer_end = 1'b0;       // boundary pulse of the other engine
  logic [11:0]       smp_time = 12'h008;    // programmed sample point
  wire  [9:0]        sense_mv;
  logic              gate_out, sync_out, err_saturated;
  logic signed [5:0] error_code;
  logic [9:0]        dac_value;
  logic [11:0]       duty_value;
  logic [1:0]        active_bank;
  int                n_errors = 0;
  int                n_compared = 0;
  vlcp_stage_model vlcp_stage_model_i (.ref_clk(ref_clk), .level_mv(level_mv), .slow(slow),
    .sense_mv(sense_mv));
  vlcp_loop vlcp_loop_i (.ref_clk(ref_clk), .rst_n(rst_n), .sense_mv(sense_mv),
    .vref_target(vref_target), .error_sample_time_cmd(smp_time), .period(period),
    .bank0(bank0), .bank1(bank1), .bank2(bank2), .ramp_active(ramp_active),
    .light_load(light_load), .sync_cfg(sync_cfg), .sync_in(sync_in), .peer_period_end(peer_end),
    .rail_index(2'h1), .gate_out(gate_out), .sync_out(sync_out), .error_code(error_code),
    .err_saturated(err_saturated), .dac_value(dac_value), .duty_value(duty_value),
    .active_bank(active_bank));
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  // coefficients: only b0 and c0 are large, so duty has no memory and simply clamps
  function automatic vlcp_bank_t mk(input logic [1:0] g, input logic [23:0] lims,
                                    input logic [7:0] n0, input logic [7:0] nm,
                                    input logic [7:0] n4);
    return {g, lims, n0, nm, nm, nm, n4, 12'h7ff, 48'h0, 12'h7ff, 24'h0};
  endfunction
  // limits -16,-4,4,16 sit inside the usual software ranges
  function automatic vlcp_bank_t pw(input logic [1:0] g);
    return mk(g, {6'h30, 6'h3c, 6'h04, 6'h10}, 8'h7f, 8'h7f, 8'h7f);
  endfunction
  task automatic clks(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic set_all(input vlcp_bank_t b);
    @(posedge ref_clk);
    bank0 <= b;
    bank1 <= b;
    bank2 <= b;
  endtask
  // d is setpoint minus sense; four periods let sample, filter and threshold settle
  task automatic settle(input int d);
    @(posedge ref_clk);
    level_mv <= vref_target - 10'(d);
    clks(128);
    #1;
  endtask
  function automatic logic signed [5:0] exp_err(input int d, input int g);
    int e;
    e = d >>> (3 - g);
    if (e > 31)
      e = 31;
    if (e < -32)
      e = -32;
    return e[5:0];
  endfunction
  // counts gate high cycles and cycles where the sync pin differs from the gate
  task automatic measure(input int n, output int hi, output int sm);
    hi = 0;
    sm = 0;
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
      hi += (gate_out === 1'b1);
      sm += (sync_out !== gate_out);
    end
  endtask
  task automatic t_gain;
    int dl[3] = '{24, -40, 248};
    int e;
    for (int g = 0; g < 4; g++)
      for (int i = 0; i < 3; i++)
      begin
        set_all(pw(2'(g)));
        settle(dl[i]);
        e = dl[i] >>> (3 - g);
        chk("error_code", exp_err(dl[i], g), error_code);
        chk("err_saturated", 16'(e > 31 || e < -32), err_saturated);
        if (e <= 31 && e >= -32)
          chk("dac_value", vref_target, dac_value);
        settle(0);
      end
  endtask
  task automatic t_slew;
    logic [9:0] d0;
    set_all(pw(2'h3));
    settle(-100);
    d0 = dac_value;
    clks(1280);
    #1;
    // 1280 clocks at one step per 128 is ten steps upward, toward the sense level
    chk("dac slew", 1'b1, (dac_value - d0 >= 10'h009) && (dac_value - d0 <= 10'h00b));
    settle(0);
    chk("dac_value", vref_target, dac_value);
  endtask
  // a sample time beyond the period never matches, so the error code must hold
  task automatic t_sample;
    logic signed [5:0] e0;
    e0 = error_code;
    @(posedge ref_clk);
    smp_time <= 12'h7ff;
    settle(5);
    chk("error_code held", e0, error_code);
    @(posedge ref_clk);
    smp_time <= 12'h008;
    settle(5);
    chk("error_code sampled", exp_err(5, 3), error_code);
    settle(0);
  endtask
  // a bank switch is deferred until the filter is idle, so wait with a bound
  task automatic t_bank;
    logic [4:0] cs[4] = '{5'h01, 5'h0a, 5'h18, 5'h10}; // {ramp, light, 1'b0, bank}
    int k;
    @(posedge ref_clk);
    bank0 <= pw(2'h0);
    bank1 <= pw(2'h3);
    bank2 <= pw(2'h1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      ramp_active <= cs[i][4];
      light_load <= cs[i][3];
      #1;
      k = 0;
      while (active_bank !== cs[i][1:0] && k < 200)
      begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      chk("active_bank", cs[i][1:0], active_bank);
      if (k == 200)
        summarize();
      settle(24);
      chk("error_code", exp_err(24, cs[i][1:0] == 2'h1 ? 3 : cs[i][1:0] == 2'h2 ? 1 : 0),
          error_code);
    end
    @(posedge ref_clk);
    ramp_active <= 1'b0;
    settle(0);
  endtask
  // a gate run of threshold cycles per period, threshold = duty * period / 4096
  task automatic t_pwm(input vlcp_bank_t b, input int d, input logic [11:0] duty);
    int hi, sm;
    set_all(b);
    settle(d);
    chk("duty_value", duty, duty_value);
    measure(32, hi, sm);
    chk("gate high count", 16'((24'(duty) * 24'(period)) >> 12), 16'(hi));
  endtask
  // one restart every 16 clocks: a four-clock sync pin pulse or a one-clock peer boundary
  task automatic pulses(input int n, input bit peer);
    repeat (n)
    begin
      @(posedge ref_clk);
      if (peer)
        peer_end <= 1'b1;
      else
        sync_in <= 1'b1;
      @(posedge ref_clk);
      peer_end <= 1'b0;
      clks(2);
      @(posedge ref_clk);
      sync_in <= 1'b0;
      clks(11);
    end
  endtask
  task automatic t_sync;
    logic [7:0] sel[3] = '{8'h01, 8'h00, 8'h05};
    int hi, sm;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge ref_clk);
      sync_cfg <= {sel[i], 8'h00};
      measure(64, hi, sm);
      chk("sync_out mismatches", sel[i] == 8'h01 ? 16'h0 : 16'(hi), 16'(sm));
    end
    // sync every 16 clocks keeps a followed counter below the 31-cycle threshold
    // m 0 follows the pin, m 1 follows nothing, m 2 follows the peer engine
    for (int m = 0; m < 3; m++)
    begin
      @(posedge ref_clk);
      sync_cfg <= m == 0 ? 16'hff02 : m == 1 ? 16'hff01 : 16'h0002;
      pulses(4, m == 2);
      fork
        pulses(8, m == 2);
        measure(128, hi, sm);
      join
      chk("gate high with sync", m == 1 ? 16'h007c : 16'h0080, 16'(hi));
    end
  endtask
  initial
  begin
    bank0 = pw(2'h3);
    bank1 = pw(2'h3);
    bank2 = pw(2'h3);
    clks(5);
    #1;
    chk("reset active_bank", 2'h1, active_bank);
    chk("reset gate_out", 1'b0, gate_out);
    chk("reset dac_value", 10'h000, dac_value);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    // raise setpoint and output together so the converter never saturates
    repeat (31)
    begin
      @(posedge ref_clk);
      vref_target <= vref_target + 10'h010;
      level_mv <= level_mv + 10'h010;
      clks(63);
    end
    @(posedge ref_clk);
    slow <= 1'b0;
    t_gain();
    $display("gain and clamp test done");
    t_slew();
    $display("slew test done");
    t_sample();
    $display("sample time test done");
    t_bank();
    $display("bank test done");
    t_pwm(pw(2'h3), 8, 12'hfff);
    t_pwm(pw(2'h3), -8, 12'h000);
    $display("pulse width test done");
    // all limits positive: gain 0 alone serves every negative error
    t_pwm(mk(2'h3, {6'h01, 6'h02, 6'h03, 6'h04}, 8'h80, 8'h00, 8'h00), -8, 12'hfff);
    t_pwm(mk(2'h3, {6'h01, 6'h02, 6'h03, 6'h04}, 8'h80, 8'h00, 8'h00), 8, 12'h000);
    $display("nonlinear gain test done");
    t_pwm(pw(2'h3), 8, 12'hfff);
    t_sync();
    $display("sync test done");
    summarize();
  end
endmodule
